/* logic/air_router.sv */
`include "air_params.svh"
`timescale 1ns/100ps

module air_router #(
  parameter logic [31:0] HOLD_250MS_CYC = 32'(`AIR_HOLD_250MS_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_500MS_CYC = 32'(`AIR_HOLD_500MS_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_1S_CYC = 32'(`AIR_HOLD_1S_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_2S_CYC = 32'(`AIR_HOLD_2S_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_4S_CYC = 32'(`AIR_HOLD_4S_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_8S_CYC = 32'(`AIR_HOLD_8S_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_250US_CYC = 32'(`AIR_HOLD_250US_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_500US_CYC = 32'(`AIR_HOLD_500US_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_1MS_CYC = 32'(`AIR_HOLD_1MS_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_12P5MS_CYC = 32'(`AIR_HOLD_12P5MS_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_25MS_CYC = 32'(`AIR_HOLD_25MS_US * `AIR_CLK_MHZ),
  parameter logic [31:0] HOLD_50MS_CYC = 32'(`AIR_HOLD_50MS_US * `AIR_CLK_MHZ),
  parameter logic [31:0] LOWG_STEP_CYC = 32'(`AIR_LOWG_STEP_US * `AIR_CLK_MHZ)
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire air_pkg::air_reg_req_t reg_req_i,
  output air_pkg::air_reg_rsp_t reg_rsp_o,
  input wire logic [`AIR_NUM_EV-1:0] event_i,
  input wire logic [`AIR_NUM_EV-1:0] engine_en_i,
  output logic [5:0] src_unfiltered_o,
  output air_pkg::air_pin_t irq_pin_a_o,
  output air_pkg::air_pin_t irq_pin_b_o
);
  import air_pkg::*;

  // ==========================================================
  // Configuration registers

  logic [7:0] route_a;
  logic [7:0] route_b;
  logic [2:0] route_q_a;
  logic [2:0] route_q_b;
  logic [5:0] src_sel;
  logic [3:0] pin_ctrl;
  logic [3:0] mode;
  logic [7:0] lowg_dur;
  logic [7:0] next_route_a;
  logic [7:0] next_route_b;
  logic [2:0] next_route_q_a;
  logic [2:0] next_route_q_b;
  logic [5:0] next_src_sel;
  logic [3:0] next_pin_ctrl;
  logic [3:0] next_mode;
  logic [7:0] next_lowg_dur;
  logic clear_cmd;

  // Reserved bits are simply not stored; they read back as zero
  always_comb
  begin
    next_route_a = route_a;
    next_route_b = route_b;
    next_route_q_a = route_q_a;
    next_route_q_b = route_q_b;
    next_src_sel = src_sel;
    next_pin_ctrl = pin_ctrl;
    next_mode = mode;
    next_lowg_dur = lowg_dur;
    clear_cmd = 1'b0;
    if (reg_req_i.wr)
    begin
      unique case (reg_req_i.addr)
        `AIR_OFS_ROUTE_A: next_route_a = reg_req_i.wdata;
        `AIR_OFS_ROUTE_B: next_route_b = reg_req_i.wdata;
        `AIR_OFS_ROUTE_Q:
        begin
          next_route_q_b = reg_req_i.wdata[`AIR_Q_B_NEWSAMPLE:`AIR_Q_B_OVERFLOW];
          next_route_q_a = reg_req_i.wdata[`AIR_Q_A_OVERFLOW:`AIR_Q_A_NEWSAMPLE];
        end
        `AIR_OFS_SRC_SEL: next_src_sel = reg_req_i.wdata[5:0];
        `AIR_OFS_PIN_CTRL: next_pin_ctrl = reg_req_i.wdata[3:0];
        `AIR_OFS_MODE:
        begin
          next_mode = reg_req_i.wdata[3:0];
          clear_cmd = reg_req_i.wdata[`AIR_MODE_CLEAR_BIT];
        end
        `AIR_OFS_LOWG_DUR: next_lowg_dur = reg_req_i.wdata;
        default:
        begin
          clear_cmd = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      route_a <= `AIR_RST_ROUTE;
      route_b <= `AIR_RST_ROUTE;
      route_q_a <= 3'h0;
      route_q_b <= 3'h0;
      src_sel <= `AIR_RST_SRC_SEL;
      pin_ctrl <= `AIR_RST_PIN_CTRL;
      mode <= `AIR_RST_MODE;
      lowg_dur <= `AIR_RST_LOWG_DUR;
    end
    else
    begin
      route_a <= next_route_a;
      route_b <= next_route_b;
      route_q_a <= next_route_q_a;
      route_q_b <= next_route_q_b;
      src_sel <= next_src_sel;
      pin_ctrl <= next_pin_ctrl;
      mode <= next_mode;
      lowg_dur <= next_lowg_dur;
    end
  end

  // Detectors pick their input path straight from the register
  assign src_unfiltered_o = src_sel;

  // ==========================================================
  // Register read-back

  logic [7:0] rd_mux;
  air_reg_rsp_t next_rsp;
  air_reg_rsp_t rsp;

  // Clear bit is write-only and always reads zero
  always_comb
  begin
    unique case (reg_req_i.addr)
      `AIR_OFS_ROUTE_A: rd_mux = route_a;
      `AIR_OFS_ROUTE_B: rd_mux = route_b;
      `AIR_OFS_ROUTE_Q: rd_mux = {route_q_b, 2'h0, route_q_a};
      `AIR_OFS_SRC_SEL: rd_mux = {2'h0, src_sel};
      `AIR_OFS_PIN_CTRL: rd_mux = {4'h0, pin_ctrl};
      `AIR_OFS_MODE: rd_mux = {4'h0, mode};
      `AIR_OFS_LOWG_DUR: rd_mux = lowg_dur;
      default: rd_mux = 8'h00;
    endcase
    next_rsp.valid = reg_req_i.rd;
    next_rsp.data = reg_req_i.rd ? rd_mux : 8'h00;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rsp <= '0;
    end
    else
    begin
      rsp <= next_rsp;
    end
  end

  assign reg_rsp_o = rsp;

  // ==========================================================
  // Mode decode: shared by all event hold stages

  air_hold_kind_t kind;
  logic [31:0] hold_cycles;

  // Bit 3 only selects the short time table; pass and latch ignore it
  always_comb
  begin
    kind = AIR_TIMED;
    hold_cycles = 32'h0;
    unique case (mode)
      4'h0, 4'h8: kind = AIR_PASS;
      4'h7, 4'hf: kind = AIR_LATCH;
      4'h1: hold_cycles = HOLD_250MS_CYC;
      4'h2: hold_cycles = HOLD_500MS_CYC;
      4'h3: hold_cycles = HOLD_1S_CYC;
      4'h4: hold_cycles = HOLD_2S_CYC;
      4'h5: hold_cycles = HOLD_4S_CYC;
      4'h6: hold_cycles = HOLD_8S_CYC;
      4'h9: hold_cycles = HOLD_250US_CYC;
      4'ha: hold_cycles = HOLD_500US_CYC;
      4'hb: hold_cycles = HOLD_1MS_CYC;
      4'hc: hold_cycles = HOLD_12P5MS_CYC;
      4'hd: hold_cycles = HOLD_25MS_CYC;
      4'he: hold_cycles = HOLD_50MS_CYC;
    endcase
  end

  // ==========================================================
  // Event qualification and hold

  logic lowg_fire;
  logic [`AIR_NUM_EV-1:0] qualified;
  logic [`AIR_NUM_EV-1:0] held;

  // Low-g level is raw condition; the delay turns it into an event
  air_lowg_delay #(
    .STEP_CYC(LOWG_STEP_CYC)
  ) u_lowg (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .cond_i(event_i[`AIR_EV_LOWG] & engine_en_i[`AIR_EV_LOWG]),
    .dur_i(lowg_dur),
    .fire_o(lowg_fire)
  );

  // Disabled engines never reach a hold stage, so cannot latch
  always_comb
  begin
    qualified = event_i & engine_en_i;
    qualified[`AIR_EV_LOWG] = lowg_fire;
  end

  for (genvar i = 0; i < `AIR_NUM_EV; i++)
  begin : g_hold
    air_hold_stage #(
      .CNT_W(32)
    ) u_stage (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .event_i(qualified[i]),
      .kind_i(kind),
      .hold_cycles_i(hold_cycles),
      .clear_i(clear_cmd),
      .held_o(held[i])
    );
  end

  // ==========================================================
  // Pin combine and electrical stage

  logic [`AIR_NUM_EV-1:0] map_a;
  logic [`AIR_NUM_EV-1:0] map_b;
  logic active_a;
  logic active_b;
  air_pin_t next_pin_a;
  air_pin_t next_pin_b;
  air_pin_t pin_a;
  air_pin_t pin_b;

  // Open drain only ever pulls low; high comes from the board pull-up
  function automatic air_pin_t drive_pin(input logic active, input logic pol,
                                         input logic od);
    air_pin_t p;
    logic lvl;
    lvl = pol ? active : ~active;
    p.level = od ? 1'b0 : lvl;
    p.oe = od ? ~lvl : 1'b1;
    return p;
  endfunction

  always_comb
  begin
    map_a = {route_q_a[2], route_q_a[1], route_q_a[0], route_a};
    map_b = {route_q_b[0], route_q_b[1], route_q_b[2], route_b};
    active_a = |(held & map_a);
    active_b = |(held & map_b);
    next_pin_a = drive_pin(active_a, pin_ctrl[`AIR_CTRL_A_POL], pin_ctrl[`AIR_CTRL_A_DRIVE]);
    next_pin_b = drive_pin(active_b, pin_ctrl[`AIR_CTRL_B_POL], pin_ctrl[`AIR_CTRL_B_DRIVE]);
  end

  // Registered so the pins never glitch on the OR tree
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      pin_a <= '{level: 1'b0, oe: 1'b1};
      pin_b <= '{level: 1'b0, oe: 1'b1};
    end
    else
    begin
      pin_a <= next_pin_a;
      pin_b <= next_pin_b;
    end
  end

  assign irq_pin_a_o = pin_a;
  assign irq_pin_b_o = pin_b;

endmodule

/* pkg/air_params.svh */
`ifndef AIR_PARAMS_SVH
`define AIR_PARAMS_SVH

// ==========================================================
// Register offsets
`define AIR_OFS_ROUTE_A 8'h19
`define AIR_OFS_ROUTE_Q 8'h1a
`define AIR_OFS_ROUTE_B 8'h1b
`define AIR_OFS_SRC_SEL 8'h1e
`define AIR_OFS_PIN_CTRL 8'h20
`define AIR_OFS_MODE 8'h21
`define AIR_OFS_LOWG_DUR 8'h22

// ==========================================================
// Reset values
`define AIR_RST_ROUTE 8'h00
`define AIR_RST_SRC_SEL 6'h00
`define AIR_RST_PIN_CTRL 4'h5
`define AIR_RST_MODE 4'h0
`define AIR_RST_LOWG_DUR 8'h09

// ==========================================================
// Field positions
`define AIR_Q_B_NEWSAMPLE 7
`define AIR_Q_B_MARK 6
`define AIR_Q_B_OVERFLOW 5
`define AIR_Q_A_OVERFLOW 2
`define AIR_Q_A_MARK 1
`define AIR_Q_A_NEWSAMPLE 0
`define AIR_CTRL_B_DRIVE 3
`define AIR_CTRL_B_POL 2
`define AIR_CTRL_A_DRIVE 1
`define AIR_CTRL_A_POL 0
`define AIR_MODE_CLEAR_BIT 7

// Event index; 7..0 follow the motion route bit order
`define AIR_EV_LOWG 0
`define AIR_EV_QMARK 9
`define AIR_EV_NEWSAMPLE 8
`define AIR_EV_QFULL 10
`define AIR_NUM_EV 11

// ==========================================================
// Timing
`define AIR_CLK_MHZ 64'd250
`define AIR_HOLD_250MS_US 64'd250000
`define AIR_HOLD_500MS_US 64'd500000
`define AIR_HOLD_1S_US 64'd1000000
`define AIR_HOLD_2S_US 64'd2000000
`define AIR_HOLD_4S_US 64'd4000000
`define AIR_HOLD_8S_US 64'd8000000
`define AIR_HOLD_250US_US 64'd250
`define AIR_HOLD_500US_US 64'd500
`define AIR_HOLD_1MS_US 64'd1000
`define AIR_HOLD_12P5MS_US 64'd12500
`define AIR_HOLD_25MS_US 64'd25000
`define AIR_HOLD_50MS_US 64'd50000
`define AIR_LOWG_STEP_US 64'd2000

`endif

/* pkg/air_pkg.sv */
package air_pkg;

  // Register access request from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } air_reg_req_t;

  // Read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } air_reg_rsp_t;

  // Interrupt pin drive: level driven and output enable
  typedef struct packed {
    logic level;
    logic oe;
  } air_pin_t;

  // Output stage behaviour decoded from the mode field
  typedef enum logic [1:0] {
    AIR_PASS,
    AIR_TIMED,
    AIR_LATCH
  } air_hold_kind_t;

endpackage

/* logic/air_hold_stage.sv */
`timescale 1ns/100ps

// ==========================================================
// Per-event hold stage: pass-through, timed hold or latch
module air_hold_stage #(
  parameter int CNT_W = 32
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic event_i,
  input wire air_pkg::air_hold_kind_t kind_i,
  input wire logic [CNT_W-1:0] hold_cycles_i,
  input wire logic clear_i,
  output logic held_o
);
  import air_pkg::*;

  logic event_q;
  logic flag;
  logic [CNT_W-1:0] cnt;
  logic next_event_q;
  logic next_flag;
  logic [CNT_W-1:0] next_cnt;
  logic rise;

  // Edge starts a hold; a rise in the clear cycle still wins
  // Flag only lives in latch mode, so an edge seen in another mode never latches later
  always_comb
  begin
    rise = event_i & ~event_q;
    next_event_q = event_i;
    next_flag = (kind_i == AIR_LATCH) & (rise | (flag & ~clear_i));
    if (rise)
    begin
      next_cnt = hold_cycles_i;
    end
    else if (clear_i || cnt == '0)
    begin
      next_cnt = '0;
    end
    else
    begin
      next_cnt = cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      event_q <= 1'b0;
      flag <= 1'b0;
      cnt <= '0;
    end
    else
    begin
      event_q <= next_event_q;
      flag <= next_flag;
      cnt <= next_cnt;
    end
  end

  // Timed hold ends on its own even if the source is still high
  always_comb
  begin
    unique case (kind_i)
      AIR_PASS: held_o = event_i;
      AIR_TIMED: held_o = (cnt != '0);
      AIR_LATCH: held_o = flag;
      default: held_o = 1'b0;
    endcase
  end

endmodule

/* logic/air_lowg_delay.sv */
`timescale 1ns/100ps

// ==========================================================
// Low-g qualifier: condition must persist (dur + 1) steps
module air_lowg_delay #(
  parameter logic [31:0] STEP_CYC = 32'd500000
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cond_i,
  input wire logic [7:0] dur_i,
  output logic fire_o
);
  logic [31:0] sub;
  logic [8:0] steps;
  logic [31:0] next_sub;
  logic [8:0] next_steps;
  logic done;

  // Steps saturate at dur + 1 so the output stays while cond holds
  always_comb
  begin
    done = (steps > {1'b0, dur_i});
    next_sub = sub;
    next_steps = steps;
    if (!cond_i)
    begin
      next_sub = '0;
      next_steps = '0;
    end
    else if (!done)
    begin
      if (sub == STEP_CYC - 32'd1)
      begin
        next_sub = '0;
        next_steps = steps + 9'd1;
      end
      else
      begin
        next_sub = sub + 32'd1;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sub <= '0;
      steps <= '0;
    end
    else
    begin
      sub <= next_sub;
      steps <= next_steps;
    end
  end

  assign fire_o = cond_i & done;

endmodule

/* testbench/air_router_chk.sv */
`timescale 1ns/100ps

// ====
// Checker on the router ports
module air_router_chk
  import air_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire air_pkg::air_reg_req_t reg_req_i,
  input wire air_pkg::air_reg_rsp_t reg_rsp_o,
  input wire logic [10:0] event_i,
  input wire logic [10:0] engine_en_i,
  input wire logic [5:0] src_unfiltered_o,
  input wire air_pkg::air_pin_t irq_pin_a_o,
  input wire air_pkg::air_pin_t irq_pin_b_o
);
  logic [3:0] ctrl, next_ctrl, pc, next_pc;
  logic [7:0] ra, next_ra, rq, next_rq;
  logic [3:0] mode, next_mode;
  logic act_a;
  logic wr;

  assign wr = reg_req_i.wr;
  // Asserted at pin A, judged with the settings the pin was built from
  assign act_a = pc[1] ? (irq_pin_a_o.oe == ~pc[0]) : (irq_pin_a_o.level == pc[0]);

  // Shadow settings; pc lags one edge, as the registered pins do
  always_comb
  begin
    next_ctrl = (wr && reg_req_i.addr == 8'h20) ? reg_req_i.wdata[3:0] : ctrl;
    next_ra = (wr && reg_req_i.addr == 8'h19) ? reg_req_i.wdata : ra;
    next_rq = (wr && reg_req_i.addr == 8'h1a) ? reg_req_i.wdata : rq;
    next_mode = (wr && reg_req_i.addr == 8'h21) ? reg_req_i.wdata[3:0] : mode;
    next_pc = ctrl;
    if (rst_i)
    begin
      next_ctrl = 4'h5;
      next_ra = 8'h00;
      next_rq = 8'h00;
      next_mode = 4'h0;
      next_pc = 4'h5;
    end
  end

  // Shadow registers
  always_ff @(posedge clk_sys_i)
  begin
    ctrl <= next_ctrl;
    ra <= next_ra;
    rq <= next_rq;
    mode <= next_mode;
    pc <= next_pc;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Clear with latch mode kept and no event for two cycles
  sequence clr_s;
    (wr && reg_req_i.addr == 8'h21 && reg_req_i.wdata[7] && reg_req_i.wdata[2:0] == 3'h7
      && event_i == 11'h0) ##1 (event_i == 11'h0 && !wr);
  endsequence

  rd_answer_a: assert property (reg_req_i.rd |=> reg_rsp_o.valid)
    else $error("read not answered");
  q_reserved_a: assert property (reg_req_i.rd && reg_req_i.addr == 8'h1a
    |=> reg_rsp_o.data[4:3] == 2'b00) else $error("reserved route bits not zero");
  clear_bit_a: assert property (reg_req_i.rd && reg_req_i.addr == 8'h21
    |=> !reg_rsp_o.data[7]) else $error("clear bit reads back");
  src_copy_a: assert property (wr && reg_req_i.addr == 8'h1e
    |=> src_unfiltered_o == $past(reg_req_i.wdata[5:0])) else $error("source select wrong");
  push_pull_a: assert property (!pc[1] |-> irq_pin_a_o.oe)
    else $error("push-pull pin not driven");
  open_drain_a: assert property (pc[1] |-> !irq_pin_a_o.level)
    else $error("open drain drives high");
  quiet_a: assert property ($past(ra == 8'h00 && rq[2:0] == 3'h0) |-> !act_a)
    else $error("unrouted pin asserted");
  pass_a: assert property ($past(mode[2:0] == 3'h0 && ra[7] && event_i[7]
    && engine_en_i[7]) |-> act_a) else $error("routed event missing on pin");
  clear_a: assert property (clr_s |=> !act_a)
    else $error("latched pin survived clear");
endmodule

/* testbench/air_host_model.sv */
`timescale 1ns/100ps

// ====
// Host side of both interrupt lines, each with a pull-up
module air_host_model
  import air_pkg::*;
(
  input wire air_pkg::air_pin_t irq_pin_a_i,
  input wire air_pkg::air_pin_t irq_pin_b_i,
  output logic wire_a_o,
  output logic wire_b_o
);
  // A released line floats up, so open drain can only pull low
  assign wire_a_o = irq_pin_a_i.oe ? irq_pin_a_i.level : 1'b1;
  assign wire_b_o = irq_pin_b_i.oe ? irq_pin_b_i.level : 1'b1;
endmodule

/* testbench/air_router_tb.sv */
`timescale 1ns/100ps

// ====
// Router bench
module air_router_tb;
  import air_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  air_reg_req_t req = '0;
  air_reg_rsp_t rsp;
  logic [10:0] ev = '0;
  logic [10:0] en = '0;
  logic [5:0] src;
  air_pin_t pa, pb;
  logic wa, wb;
  logic pol = 1'b1;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;

  // 250 MHz clock
  always #2 clk_sys_i = ~clk_sys_i;

  // Short holds keep the run brief; each timed code gets a length of its own
  air_router #(
    .HOLD_250MS_CYC(32'd40),
    .HOLD_500MS_CYC(32'd44),
    .HOLD_1S_CYC(32'd48),
    .HOLD_2S_CYC(32'd52),
    .HOLD_4S_CYC(32'd56),
    .HOLD_8S_CYC(32'd60),
    .HOLD_250US_CYC(32'd20),
    .HOLD_500US_CYC(32'd22),
    .HOLD_1MS_CYC(32'd24),
    .HOLD_12P5MS_CYC(32'd26),
    .HOLD_25MS_CYC(32'd28),
    .HOLD_50MS_CYC(32'd30),
    .LOWG_STEP_CYC(32'd10)
  ) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_req_i(req), .reg_rsp_o(rsp), .event_i(ev),
    .engine_en_i(en), .src_unfiltered_o(src), .irq_pin_a_o(pa), .irq_pin_b_o(pb));
  air_host_model host_u (.irq_pin_a_i(pa), .irq_pin_b_i(pb), .wire_a_o(wa), .wire_b_o(wb));

  task automatic wrap_up();
    $display("checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // Extra idle cycle so a following write never re-raises the strobe at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    step(1);
    req.wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.rd = 1'b1;
    req.addr = a;
    step(1);
    req.rd = 1'b0;
    chk("valid", {7'h0, rsp.valid}, 8'h01);
    chk("rdata", rsp.data, exp);
    step(1);
  endtask

  // Host sees the asserted level equal to the polarity
  task automatic pins(input logic a, input logic b);
    chk("pin a", {7'h0, wa}, {7'h0, a ~^ pol});
    chk("pin b", {7'h0, wb}, {7'h0, b ~^ pol});
  endtask

  task automatic pulse(input int i);
    ev[i] = 1'b1;
    step(1);
    ev[i] = 1'b0;
  endtask

  // Hang guard, far above the roughly 800 cycles needed
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  initial
  begin
    step(4);
    rst_i = 1'b0;
    rd(8'h19, 8'h00);
    rd(8'h1b, 8'h00);
    rd(8'h1e, 8'h00);
    rd(8'h20, 8'h05);
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h09);
    rd(8'h1c, 8'h00);
    wr(8'h1a, 8'he7);
    rd(8'h1a, 8'he7);
    wr(8'h1e, 8'h3f);
    chk("source", {2'b0, src}, 8'h3f);
    wr(8'h1e, 8'h20);
    chk("source", {2'b0, src}, 8'h20);
    wr(8'h21, 8'h8f);
    rd(8'h21, 8'h0f);
    wr(8'h21, 8'h00);
    wr(8'h1a, 8'h00);
    en = 11'h7ff;
    // Each motion event to one pin only; low-g is slow and has its own scenario
    for (int i = 1; i < 8; i++)
    begin
      wr(8'h19, 8'h01 << i);
      wr(8'h1b, 8'h01 << (i % 7 + 1));
      ev = 11'h001 << i;
      step(2);
      pins(1'b1, 1'b0);
      ev = 11'h001 << (i % 7 + 1);
      step(2);
      pins(1'b0, 1'b1);
      ev = '0;
      step(1);
    end
    wr(8'h19, 8'h00);
    wr(8'h1b, 8'h00);
    // Queue and new-sample events, pin A then pin B
    for (int j = 0; j < 3; j++)
    begin
      wr(8'h1a, 8'h01 << j);
      ev = 11'h100 << j;
      step(2);
      pins(1'b1, 1'b0);
      wr(8'h1a, 8'h80 >> j);
      pins(1'b0, 1'b1);
      ev = '0;
      step(1);
    end
    en = 11'h3ff;
    ev = 11'h400;
    step(3);
    pins(1'b0, 1'b0);
    ev = '0;
    en = 11'h7ff;
    wr(8'h19, 8'h80);
    wr(8'h1b, 8'h80);
    // Every polarity and drive type combination
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h20, 8'(k * 5));
      pol = k[0];
      pins(1'b0, 1'b0);
      ev = 11'h080;
      step(2);
      pins(1'b1, 1'b1);
      ev = '0;
      step(2);
    end
    wr(8'h21, 8'h07);
    pulse(7);
    step(5);
    pins(1'b1, 1'b1);
    wr(8'h21, 8'h07);
    step(1);
    pins(1'b1, 1'b1);
    wr(8'h21, 8'h8f);
    step(1);
    pins(1'b0, 1'b0);
    pulse(7);
    step(5);
    pins(1'b1, 1'b1);
    wr(8'h21, 8'h88);
    step(1);
    pins(1'b0, 1'b0);
    ev = 11'h080;
    step(2);
    pins(1'b1, 1'b1);
    ev = '0;
    step(2);
    pins(1'b0, 1'b0);
    wr(8'h21, 8'h09);
    pulse(7);
    step(10);
    pins(1'b1, 1'b1);
    step(20);
    pins(1'b0, 1'b0);
    wr(8'h21, 8'h01);
    pulse(7);
    step(30);
    pins(1'b1, 1'b1);
    step(20);
    pins(1'b0, 1'b0);
    // Every timed code: last held cycle, then the first free one
    for (int c = 1; c < 15; c++)
    begin
      if (c != 7 && c != 8)
      begin
        wr(8'h21, 8'(c));
        pulse(7);
        step(c < 8 ? 36 + 4 * c : 2 * c + 2);
        pins(1'b1, 1'b1);
        step(1);
        pins(1'b0, 1'b0);
      end
    end
    // Low-g needs (2 + 1) steps of 10 cycles
    wr(8'h21, 8'h00);
    wr(8'h19, 8'h01);
    wr(8'h1b, 8'h01);
    wr(8'h22, 8'h02);
    ev = 11'h001;
    step(25);
    pins(1'b0, 1'b0);
    step(10);
    pins(1'b1, 1'b1);
    ev = '0;
    step(2);
    pins(1'b0, 1'b0);
    wrap_up();
  end
endmodule

bind air_router air_router_chk chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .reg_req_i(reg_req_i), .reg_rsp_o(reg_rsp_o), .event_i(event_i),
  .engine_en_i(engine_en_i), .src_unfiltered_o(src_unfiltered_o),
  .irq_pin_a_o(irq_pin_a_o), .irq_pin_b_o(irq_pin_b_o));
